// ---- logic/axh_regs.svh ----
`ifndef AXH_REGS_SVH
`define AXH_REGS_SVH
// Own register offsets, byte addresses on APB.
`define AXH_OFS_CTRL 8'h00
`define AXH_OFS_SAMPLE0 8'h04
`define AXH_OFS_STATUS 8'h14
`define AXH_OFS_IMAGE 8'h18
`define AXH_SAMPLE_CNT 4
// Control register fields.
`define AXH_CTRL_ENABLE 0
`define AXH_CTRL_CFG_TWO 1
`define AXH_CTRL_PSPD 2
`define AXH_CTRL_CSPD 4
`define AXH_CTRL_PLINE 6
`define AXH_CTRL_CLINE 8
`define AXH_CTRL_FMT 10
`define AXH_CTRL_RESET 32'h0000_0000
// Status register fields.
`define AXH_STAT_VALID 0
`define AXH_STAT_RATE_OK 1
`define AXH_STAT_RUN 2
`define AXH_STAT_HALF 8
// Device register images: speed_and_clock_select fields.
`define AXH_D03_PSPD 6
`define AXH_D03_CSPD 4
`define AXH_D03_CAP_CLK 0
// serial_format_and_line_mode fields.
`define AXH_D04_FMT 4
`define AXH_D04_CLINE 2
`define AXH_D04_PLINE 0
// port_role_and_aux_clock fields.
`define AXH_D05_PMASTER 7
`define AXH_D05_CMASTER 6
`define AXH_D05_AUXSRC 5
// Field codes.
`define AXH_SPD_SINGLE 2'h0
`define AXH_SPD_DOUBLE 2'h1
`define AXH_SPD_RSVD 2'h3
`define AXH_LINE_OFF 2'h0
`define AXH_LINE_ONE 2'h1
`define AXH_LINE_TWO 2'h2
`define AXH_LINE_RSVD 2'h3
// Sample framing: bits per sample, bit clocks per half frame.
`define AXH_SAMPLE_BITS 24
`define AXH_HALF_64FS 7'h20
`define AXH_HALF_128FS 7'h40
`define AXH_CNT_MAX 7'h7F
`endif

// ---- logic/axh_pkg.sv ----
package axh_pkg;
    typedef enum logic [1:0] {
        AXH_IDLE = 2'b01,
        AXH_RUN = 2'b10
    } axh_mode_t;

    typedef struct packed {
        logic [2:0] fmt;
        logic [1:0] cap_line;
        logic [1:0] play_line;
        logic [1:0] cap_speed;
        logic [1:0] play_speed;
        logic cfg_two;
        logic enable;
    } axh_ctrl_t;

    typedef struct packed {
        logic [7:0] speed_img;
        logic [7:0] format_img;
        logic [7:0] role_img;
    } axh_image_t;

    typedef struct packed {
        axh_mode_t mode;
        axh_ctrl_t ctrl;
        logic [3:0][23:0] sample;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic bclk_last;
        logic lrck_last;
        logic [1:0][23:0] shift;
        logic [1:0] sdata;
        logic [6:0] bit_cnt;
        logic [6:0] half_len;
        logic rate_ok;
        logic cfg_valid;
        axh_image_t image;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } axh_state_t;
endpackage

// ---- logic/axh_host.sv ----
// Summary of operation
// - Auxiliary inputs carry left-justified 24-bit samples at 64 or 128 Fs.
// - Single speed accepts 64 or 128 Fs bit clock on auxiliary inputs.
// - Double speed accepts only 64 Fs bit clock on auxiliary inputs.
// - Quad speed is unsupported on auxiliary inputs.
// - Aux clock source bit 1 picks playback clocks, 0 capture clocks.
// - Configuration one needs equal playback and capture speed fields.
// - Configuration one needs both serial ports as clock masters.
// - Configuration one needs aux clock source bit at 0.
// - Configuration one line fields must form an allowed combination.
// - Configuration two limits playback line field to 00 or 01.
// - Configuration two needs both masters and aux clock source bit 1.
`timescale 1ns/1ps
`default_nettype none
`include "axh_regs.svh"

module axh_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic playback_bit_clock,
    input wire logic playback_frame_clock,
    input wire logic capture_bit_clock,
    input wire logic capture_frame_clock,
    output logic aux_converter_input_a,
    output logic aux_converter_input_b,
    output logic config_valid,
    output logic [7:0] dev_speed_img,
    output logic [7:0] dev_format_img,
    output logic [7:0] dev_role_img
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************

    function automatic logic axh_mapped(input logic [7:0] addr);
        axh_mapped = (addr == `AXH_OFS_CTRL) || (addr == `AXH_OFS_STATUS) ||
                     (addr == `AXH_OFS_IMAGE) ||
                     ((addr >= `AXH_OFS_SAMPLE0) && (addr < `AXH_OFS_STATUS) &&
                      (addr[1:0] == 2'h0));
    endfunction

    // Checks the requested settings before they reach the device.
    function automatic logic axh_cfg_ok(input axh_pkg::axh_ctrl_t c);
        logic ok;
        ok = 1'b1;
        if ((c.play_speed == `AXH_SPD_RSVD) ||
            (c.cap_speed == `AXH_SPD_RSVD)) begin
            ok = 1'b0;
        end
        if ((c.play_line == `AXH_LINE_RSVD) ||
            (c.cap_line == `AXH_LINE_RSVD)) begin
            ok = 1'b0;
        end
        if ((c.play_line == `AXH_LINE_TWO) &&
            (c.play_speed != `AXH_SPD_SINGLE)) begin
            ok = 1'b0;
        end
        if (!c.cfg_two) begin
            if (c.play_speed != c.cap_speed) begin
                ok = 1'b0;
            end
            if ((c.play_line == `AXH_LINE_TWO) &&
                (c.cap_line != `AXH_LINE_TWO)) begin
                ok = 1'b0;
            end
            if ((c.cap_line == `AXH_LINE_TWO) &&
                (c.play_line == `AXH_LINE_ONE)) begin
                ok = 1'b0;
            end
        end else begin
            if (c.play_line == `AXH_LINE_TWO) begin
                ok = 1'b0;
            end
            if ((c.cap_line == `AXH_LINE_TWO) &&
                (c.play_line != `AXH_LINE_OFF)) begin
                ok = 1'b0;
            end
        end
        axh_cfg_ok = ok;
    endfunction

    // ************************************************************
    // State
    // ************************************************************

    axh_pkg::axh_state_t s_reg;
    axh_pkg::axh_state_t s_next;

    logic bclk;
    logic lrck;
    logic bclk_fall;
    logic multiplexed_line_operation;
    logic [1:0] spd;
    logic [2:0] sidx;
    logic [1:0] rsel;

    always_comb begin
        s_next = s_reg;
        sidx = 3'h0;
        s_next.sync1 = {capture_frame_clock, capture_bit_clock,
                        playback_frame_clock, playback_bit_clock};
        s_next.sync2 = s_reg.sync1;

        // The aux clock source follows the configuration choice.
        bclk = s_reg.ctrl.cfg_two ? s_reg.sync2[0] : s_reg.sync2[2];
        lrck = s_reg.ctrl.cfg_two ? s_reg.sync2[1] : s_reg.sync2[3];
        spd = s_reg.ctrl.cfg_two ? s_reg.ctrl.play_speed :
                                   s_reg.ctrl.cap_speed;
        s_next.bclk_last = bclk;
        bclk_fall = s_reg.bclk_last & ~bclk;
        multiplexed_line_operation = (s_reg.ctrl.play_line != `AXH_LINE_OFF) ||
              (s_reg.ctrl.cap_line != `AXH_LINE_OFF);
        s_next.cfg_valid = axh_cfg_ok(s_reg.ctrl);

        // ********************************************************
        // Device register images
        // ********************************************************
        // Checked on the live settings so a bad write never leaks out.
        if (axh_cfg_ok(s_reg.ctrl)) begin
            s_next.image.speed_img = 8'h00;
            s_next.image.speed_img[`AXH_D03_PSPD +: 2] = s_reg.ctrl.play_speed;
            s_next.image.speed_img[`AXH_D03_CSPD +: 2] = s_reg.ctrl.cap_speed;
            // Capture output runs on playback clocks in configuration two.
            s_next.image.speed_img[`AXH_D03_CAP_CLK] =
                s_reg.ctrl.cfg_two;
            s_next.image.format_img = 8'h00;
            s_next.image.format_img[`AXH_D04_FMT +: 3] = s_reg.ctrl.fmt;
            s_next.image.format_img[`AXH_D04_CLINE +: 2] = s_reg.ctrl.cap_line;
            s_next.image.format_img[`AXH_D04_PLINE +: 2] = s_reg.ctrl.play_line;
            s_next.image.role_img = 8'h00;
            s_next.image.role_img[`AXH_D05_PMASTER] = 1'b1;
            s_next.image.role_img[`AXH_D05_CMASTER] = 1'b1;
            s_next.image.role_img[`AXH_D05_AUXSRC] =
                s_reg.ctrl.cfg_two;
        end

        // ********************************************************
        // Auxiliary converter serialiser
        // ********************************************************
        case (s_reg.mode)
            axh_pkg::AXH_IDLE: begin
                s_next.sdata = 2'h0;
                if (s_reg.ctrl.enable && s_reg.cfg_valid && multiplexed_line_operation) begin
                    s_next.mode = axh_pkg::AXH_RUN;
                    s_next.lrck_last = lrck;
                    s_next.bit_cnt = `AXH_CNT_MAX;
                end
            end
            axh_pkg::AXH_RUN: begin
                if (!(s_reg.ctrl.enable && s_reg.cfg_valid && multiplexed_line_operation)) begin
                    s_next.mode = axh_pkg::AXH_IDLE;
                    s_next.sdata = 2'h0;
                end else if (bclk_fall) begin
                    // Data changes on the falling edge so the device
                    // sees it stable at the next rising edge.
                    if (lrck != s_reg.lrck_last) begin
                        s_next.lrck_last = lrck;
                        s_next.half_len = s_reg.bit_cnt;
                        s_next.bit_cnt = 7'h01;
                        for (int i = 0; i < 2; i++) begin
                            // Left sample while the frame clock is high.
                            sidx = 3'(i * 2) + {2'h0, ~lrck};
                            s_next.sdata[i] =
                                s_reg.sample[sidx[1:0]][23];
                            s_next.shift[i] =
                                {s_reg.sample[sidx[1:0]][22:0], 1'b0};
                        end
                    end else begin
                        if (s_reg.bit_cnt != `AXH_CNT_MAX) begin
                            s_next.bit_cnt = s_reg.bit_cnt + 7'h01;
                        end
                        for (int i = 0; i < 2; i++) begin
                            s_next.sdata[i] = s_reg.shift[i][23];
                            s_next.shift[i] = {s_reg.shift[i][22:0], 1'b0};
                        end
                    end
                end
            end
            default: begin
                s_next.mode = axh_pkg::AXH_IDLE;
                s_next.sdata = 2'h0;
            end
        endcase

        // Bit clock ratio check against the selected speed.
        s_next.rate_ok =
            ((spd == `AXH_SPD_SINGLE) &&
             ((s_reg.half_len == `AXH_HALF_64FS) ||
              (s_reg.half_len == `AXH_HALF_128FS))) ||
            ((spd == `AXH_SPD_DOUBLE) &&
             (s_reg.half_len == `AXH_HALF_64FS));

        // ********************************************************
        // APB slave
        // ********************************************************
        rsel = paddr[3:2] - 2'h1;
        if (psel && !penable) begin
            s_next.pready = 1'b1;
            s_next.pslverr = !axh_mapped(paddr);
            s_next.prdata = 32'h0000_0000;
            if (paddr == `AXH_OFS_CTRL) begin
                s_next.prdata[12:0] = s_reg.ctrl;
            end else if (paddr == `AXH_OFS_STATUS) begin
                s_next.prdata[`AXH_STAT_VALID] = s_reg.cfg_valid;
                s_next.prdata[`AXH_STAT_RATE_OK] = s_reg.rate_ok;
                s_next.prdata[`AXH_STAT_RUN] =
                    (s_reg.mode == axh_pkg::AXH_RUN);
                s_next.prdata[`AXH_STAT_HALF +: 7] = s_reg.half_len;
            end else if (paddr == `AXH_OFS_IMAGE) begin
                s_next.prdata[23:0] = s_reg.image;
            end else if (axh_mapped(paddr)) begin
                s_next.prdata[23:0] = s_reg.sample[rsel];
            end
        end else if (psel && penable && s_reg.pready) begin
            s_next.pready = 1'b0;
            s_next.pslverr = 1'b0;
            if (pwrite && !s_reg.pslverr) begin
                if (paddr == `AXH_OFS_CTRL) begin
                    s_next.ctrl.enable = pwdata[`AXH_CTRL_ENABLE];
                    s_next.ctrl.cfg_two = pwdata[`AXH_CTRL_CFG_TWO];
                    s_next.ctrl.play_speed = pwdata[`AXH_CTRL_PSPD +: 2];
                    s_next.ctrl.cap_speed = pwdata[`AXH_CTRL_CSPD +: 2];
                    s_next.ctrl.play_line = pwdata[`AXH_CTRL_PLINE +: 2];
                    s_next.ctrl.cap_line = pwdata[`AXH_CTRL_CLINE +: 2];
                    s_next.ctrl.fmt = pwdata[`AXH_CTRL_FMT +: 3];
                end else if ((paddr != `AXH_OFS_STATUS) &&
                             (paddr != `AXH_OFS_IMAGE)) begin
                    s_next.sample[rsel] = pwdata[23:0];
                end
            end
        end else begin
            s_next.pready = 1'b0;
            s_next.pslverr = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.mode <= axh_pkg::AXH_IDLE;
            s_reg.ctrl <= 13'(`AXH_CTRL_RESET);
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign aux_converter_input_a = s_reg.sdata[0];
    assign aux_converter_input_b = s_reg.sdata[1];
    assign config_valid = s_reg.cfg_valid;
    assign dev_speed_img = s_reg.image.speed_img;
    assign dev_format_img = s_reg.image.format_img;
    assign dev_role_img = s_reg.image.role_img;

endmodule
`default_nettype wire

// ---- verification/axh_host_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module axh_host_properties (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic playback_bit_clock,
    input wire logic capture_bit_clock,
    input wire logic aux_converter_input_a,
    input wire logic aux_converter_input_b,
    input wire logic config_valid,
    input wire logic [7:0] dev_speed_img,
    input wire logic [7:0] dev_format_img,
    input wire logic [7:0] dev_role_img
);
    // ************************************************************
    // Checks on the bus answer, the device images and the lines.
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_valid_run;
        config_valid [*3];
    endsequence
    sequence s_invalid_run;
        !config_valid [*5];
    endsequence
    a_apb_zero_wait: assert property (s_setup |=> pready)
        else $error("pready missing in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_clock_pairing: assert property (dev_speed_img[0] == dev_role_img[5])
        else $error("capture clock select and aux source disagree");
    a_master_bits: assert property (s_valid_run |-> dev_role_img[7:6] == 2'h3)
        else $error("serial ports not both masters");
    a_line_codes: assert property (dev_format_img[1:0] != 2'h3 &&
        dev_format_img[3:2] != 2'h3)
        else $error("reserved line code reached the device");
    a_equal_speeds: assert property (!dev_speed_img[0] |->
        dev_speed_img[7:6] == dev_speed_img[5:4])
        else $error("configuration one with unequal speeds");
    a_cfg_two_line: assert property (dev_speed_img[0] |->
        dev_format_img[1:0] != 2'h2)
        else $error("second playback arrangement in configuration two");
    a_idle_quiet: assert property (s_invalid_run |->
        !aux_converter_input_a && !aux_converter_input_b)
        else $error("aux data while configuration invalid");
    a_shift_on_fall: assert property ($rose(aux_converter_input_a) |->
        $past(playback_bit_clock, 8) && !$past(playback_bit_clock, 1))
        else $error("aux data changed away from a bit clock fall");
endmodule
`default_nettype wire

// ---- verification/axh_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module axh_dev_model (
    input wire logic aux_converter_input_a,
    input wire logic aux_converter_input_b,
    input wire logic [7:0] dev_role_img,
    input wire logic [6:0] play_half,
    input wire logic [6:0] cap_half,
    output logic playback_bit_clock,
    output logic playback_frame_clock,
    output logic capture_bit_clock,
    output logic capture_frame_clock,
    output logic [3:0][23:0] got,
    output int n_cap
);
    // ************************************************************
    // Device side: both ports are clock masters on one bit clock.
    // ************************************************************
    logic [7:0] port_role_and_aux_clock;
    logic bclk = 1'b0;
    logic pfr = 1'b0;
    logic cfr = 1'b0;
    logic lfr = 1'b0;
    logic sel_fr;
    logic [23:0] wa, wb;
    int pc = 0;
    int cc = 0;
    int n = 99;
    assign port_role_and_aux_clock = dev_role_img;
    assign playback_bit_clock = bclk;
    assign capture_bit_clock = bclk;
    assign playback_frame_clock = pfr;
    assign capture_frame_clock = cfr;
    assign sel_fr = port_role_and_aux_clock[5] ? pfr : cfr;
    initial begin
        #13;
        forever #40 bclk = ~bclk;
    end
    always @(negedge bclk) begin
        pc = (pc + 1) % play_half;
        cc = (cc + 1) % cap_half;
        if (pc == 0)
            pfr = ~pfr;
        if (cc == 0)
            cfr = ~cfr;
    end
    always @(posedge bclk) begin
        n = (sel_fr != lfr) ? 0 : n + 1;
        lfr = sel_fr;
        wa = {wa[22:0], aux_converter_input_a};
        wb = {wb[22:0], aux_converter_input_b};
        if (n == 23) begin
            got[sel_fr ? 0 : 1] = wa;
            got[sel_fr ? 2 : 3] = wb;
            n_cap = n_cap + 1;
        end
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "axh_regs.svh"
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [6:0] ph = 7'h20;
    logic [6:0] ch = 7'h20;
    logic [31:0] prdata, q;
    logic pready, pslverr, pb, pf, cb, cf, ax_a, ax_b, cfg_ok, e;
    logic [7:0] img_s, img_f, img_r;
    logic [3:0][23:0] got, smp;
    logic [31:0] bad [3] = '{32'h0000_1445, 32'h0000_00C1, 32'h0000_0083};
    int n_cap, failures, n_checks;
    always #2.5 clk_sys = ~clk_sys;
    axh_host dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .playback_bit_clock(pb), .playback_frame_clock(pf),
        .capture_bit_clock(cb), .capture_frame_clock(cf),
        .aux_converter_input_a(ax_a), .aux_converter_input_b(ax_b),
        .config_valid(cfg_ok), .dev_speed_img(img_s),
        .dev_format_img(img_f), .dev_role_img(img_r));
    axh_dev_model partner (.aux_converter_input_a(ax_a),
        .aux_converter_input_b(ax_b), .dev_role_img(img_r),
        .play_half(ph), .cap_half(ch), .playback_bit_clock(pb),
        .playback_frame_clock(pf), .capture_bit_clock(cb),
        .capture_frame_clock(cf), .got(got), .n_cap(n_cap));
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang(input string what);
        failures++;
        $display("BAD %0t %s timeout", $time, what);
        end_sim();
    endtask
    task automatic chk(input logic [31:0] gv, ev, input string what);
        n_checks++;
        if (gv !== ev) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, gv, ev);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (k >= 64)
            hang("bus");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ev, m,
                      input string what);
        xfer(1'b0, a, 32'h0000_0000);
        chk(q & m, ev, what);
    endtask
    task automatic run_cfg(input logic [31:0] c, input logic [6:0] p, cc,
                           input logic [31:0] img, st, m, input logic dchk);
        int k, n0;
        ph <= p;
        ch <= cc;
        xfer(1'b1, `AXH_OFS_CTRL, c);
        n0 = n_cap;
        k = 0;
        while (n_cap < n0 + 4 && k < 30000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 30000)
            hang("frame");
        rd(`AXH_OFS_IMAGE, img, 32'hFFFF_FFFF, "image");
        rd(`AXH_OFS_STATUS, st, m, "status");
        for (int i = 0; i < 4 && dchk; i++)
            chk({8'h00, got[i]}, {8'h00, smp[i]}, "aux sample");
    endtask
    initial begin
        smp = {24'h3C5A96, 24'h0F1E2D, 24'h817E55, 24'hA5C3F1};
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(`AXH_OFS_CTRL, `AXH_CTRL_RESET, 32'hFFFF_FFFF, "ctrl reset");
        rd(`AXH_OFS_IMAGE, 32'h0000_00C0, 32'hFFFF_FFFF, "image");
        xfer(1'b0, 8'h1C, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001, "unmapped error");
        chk(q, 32'h0000_0000, "unmapped data");
        for (int i = 0; i < `AXH_SAMPLE_CNT; i++) begin
            xfer(1'b1, `AXH_OFS_SAMPLE0 + 8'(4 * i), {8'hFF, smp[i]});
            rd(`AXH_OFS_SAMPLE0 + 8'(4 * i), {8'h00, smp[i]}, 32'hFFFF_FFFF,
               "sample");
        end
        xfer(1'b1, `AXH_OFS_STATUS, 32'hFFFF_FFFF);
        run_cfg(32'h1441, 7'h20, 7'h20, 32'h0000_51C0, 32'h2007,
                32'h7F07, 1'b1);
        run_cfg(32'h0053, 7'h40, 7'h20, 32'h0011_01E0, 32'h4007,
                32'h7F07, 1'b1);
        run_cfg(32'h0055, 7'h40, 7'h40, 32'h0050_01C0, 32'h4005,
                32'h7F07, 1'b0);
        foreach (bad[i])
            run_cfg(bad[i], 7'h40, 7'h40, 32'h0050_01C0, 32'h0000,
                    32'h0001, 1'b0);
        end_sim();
    end
endmodule
bind axh_host axh_host_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .playback_bit_clock(playback_bit_clock),
    .capture_bit_clock(capture_bit_clock),
    .aux_converter_input_a(aux_converter_input_a),
    .aux_converter_input_b(aux_converter_input_b),
    .config_valid(config_valid), .dev_speed_img(dev_speed_img),
    .dev_format_img(dev_format_img), .dev_role_img(dev_role_img));
`default_nettype wire
